// ===== ast_pkg.sv
// Package for the asynchronous serial transceiver: register map, fields, states.
// Assumes a single 50 MHz clock domain and an 8-bit register port.
package ast_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [2:0] AST_OFS_MODE   = 3'h0;
   localparam logic [2:0] AST_OFS_CTRL   = 3'h1;
   localparam logic [2:0] AST_OFS_STAT   = 3'h2;
   localparam logic [2:0] AST_OFS_TXBUF  = 3'h3;
   localparam logic [2:0] AST_OFS_RXBUF  = 3'h4;
   localparam logic [2:0] AST_OFS_DIV    = 3'h5;

   // ****************************************
   // Reset values and counts
   // ****************************************
   localparam logic [7:0] AST_MODE_RST   = 8'h00;
   localparam logic [7:0] AST_CTRL_RST   = 8'h00;
   localparam logic [7:0] AST_DIV_RST    = 8'h1a;
   localparam logic [7:0] AST_STAT_RST   = 8'h84;
   localparam logic [3:0] AST_PH_SAMPLE  = 4'h7;
   localparam logic [3:0] AST_PH_LAST    = 4'hf;
   localparam int         AST_OVERSAMPLE = 16;

   // ****************************************
   // Field layouts
   // ****************************************
   typedef struct packed {
      logic sync_mode_select;
      logic seven_bit_select;
      logic parity_enable;
      logic parity_odd_select;
      logic two_stop_select;
      logic multiproc_format;
      logic [1:0] spare;
   } ast_mode_t;

   typedef struct packed {
      logic tx_empty_irq_en;
      logic rx_irq_en;
      logic tx_enable;
      logic rx_enable;
      logic spare;
      logic tx_end_irq_en;
      logic clk_sel_hi;
      logic clk_sel_lo;
   } ast_ctrl_t;

   typedef struct packed {
      logic tx_empty_flag;
      logic rx_full_flag;
      logic overrun_flag;
      logic framing_flag;
      logic parity_flag;
      logic tx_end_flag;
      logic multiproc_bit;
      logic multiproc_tx_bit;
   } ast_stat_t;

   // ****************************************
   // State machines
   // ****************************************
   typedef enum logic [4:0] {
      AST_TX_IDLE  = 5'b00001,
      AST_TX_START = 5'b00010,
      AST_TX_DATA  = 5'b00100,
      AST_TX_PAR   = 5'b01000,
      AST_TX_STOP  = 5'b10000
   } ast_tx_st_t;

   typedef enum logic [4:0] {
      AST_RX_IDLE  = 5'b00001,
      AST_RX_START = 5'b00010,
      AST_RX_DATA  = 5'b00100,
      AST_RX_PAR   = 5'b01000,
      AST_RX_STOP  = 5'b10000
   } ast_rx_st_t;

endpackage

// ===== ast_remote.sv
// Remote serial device model: sends frames on rxd, captures frames from txd.
// Assumes bit times are given in system clock cycles by the caller.
`timescale 1ns/1ps
`default_nettype none

module ast_remote (
   input  wire logic clk,
   input  wire logic txd,
   input  wire logic sclk,
   output logic      rxd,
   output logic      ext_clk
);
   time t0;

   // ****************************
   // Idle line and 16x clock
   // ****************************
   initial
   begin
      rxd = 1'b1;
      ext_clk = 1'b0;
      t0 = 0;
   end

   // Never stopped, tick every 4 clk
   always #40 ext_clk = ~ext_clk;

   // ****************************
   // Frame tasks
   // ****************************
   task automatic send(input logic [11:0] f, input int nb, input int bt);
      for (int i = 0; i < nb; i++)
      begin
         @(posedge clk);
         rxd <= f[i];
         repeat (bt - 1) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'b1;
   endtask

   task automatic recv(input int nb, input int bt, output logic [11:0] f,
                       output logic [11:0] c0, output logic [11:0] c1);
      f = '0;
      c0 = '0;
      c1 = '0;
      @(negedge txd);
      t0 = $time;
      for (int i = 0; i < nb; i++)
      begin
         repeat (bt / 4) @(negedge clk);
         c0[i] = sclk;
         repeat (bt / 4) @(negedge clk);
         f[i] = txd;
         if (i < nb - 1)
         begin
            repeat (bt / 4) @(negedge clk);
            c1[i] = sclk;
            repeat (bt / 4) @(negedge clk);
         end
      end
   endtask
endmodule

`default_nettype wire

// ===== ast_serial_unit.sv
// Asynchronous serial transceiver: register port, 16x tick, transmitter, receiver.
// Assumes clk at 50 MHz, srst synchronous; rxd and serial_clk_in are asynchronous pins.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module ast_serial_unit
   import ast_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       rxd,
   output logic            txd,
   input  wire logic       serial_clk_in,
   output logic            serial_clk_out,
   output logic            serial_clk_oe,
   output logic            tx_empty_irq,
   output logic            tx_end_irq,
   output logic            rx_full_irq,
   output logic            rx_error_irq
);

   // ****************************************
   // Registers and state
   // ****************************************
   ast_mode_t  mode_r;
   ast_ctrl_t  ctrl_r;
   ast_stat_t  stat_r;
   logic [7:0] div_r;
   logic [7:0] tx_buffer_r;
   logic [7:0] rx_buffer_r;
   logic [7:0] rdata_r;
   logic [7:0] div_cnt_r;
   logic [2:0] rxd_sync_r;
   logic [2:0] sck_sync_r;
   logic       tick;
   ast_tx_st_t tx_st_r;
   logic [3:0] tx_ph_r;
   logic [2:0] tx_cnt_r;
   logic [7:0] tx_shifter_r;
   logic       tx_par_r;
   logic       txd_r;
   logic       txd_nxt;
   logic       tx_bnd;
   logic       tx_load;
   logic       tx_finish;
   logic [2:0] last_data;
   ast_rx_st_t rx_st_r;
   logic [3:0] rx_ph_r;
   logic [2:0] rx_cnt_r;
   logic [7:0] rx_shifter_r;
   logic       rx_par_r;
   logic       rx_smp;
   logic       rx_done;
   logic       rx_line;
   logic       rx_err_any;
   logic       rx_start;
   logic       par_bad;
   logic       has_pbit;
   logic       wr_stat;

   assign rx_line    = rxd_sync_r[1];
   assign last_data  = mode_r.seven_bit_select ? 3'h6 : 3'h7;
   assign has_pbit   = mode_r.parity_enable | mode_r.multiproc_format;
   assign rx_err_any = stat_r.overrun_flag | stat_r.framing_flag | stat_r.parity_flag;
   assign wr_stat    = wr && (addr == AST_OFS_STAT);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rxd_sync_r <= 3'h7;
         sck_sync_r <= 3'h0;
      end
      else if (ce)
      begin
         rxd_sync_r <= {rxd_sync_r[1:0], rxd};
         sck_sync_r <= {sck_sync_r[1:0], serial_clk_in};
      end
   end

   // ****************************************
   // 16x tick source
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (srst)
         div_cnt_r <= 8'h00;
      else if (ce)
         div_cnt_r <= (div_cnt_r >= div_r) ? 8'h00 : div_cnt_r + 8'h01;
   end

   always_comb
   begin
      if (ctrl_r.clk_sel_hi)
         tick = sck_sync_r[1] & ~sck_sync_r[2];
      else
         tick = (div_cnt_r >= div_r);
   end

   assign serial_clk_oe  = ~mode_r.sync_mode_select & ~ctrl_r.clk_sel_hi & ctrl_r.clk_sel_lo;
   assign serial_clk_out = tx_ph_r[3];

   // ****************************************
   // Register port
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mode_r <= AST_MODE_RST;
         ctrl_r <= AST_CTRL_RST;
         div_r  <= AST_DIV_RST;
      end
      else if (ce && wr)
      begin
         if (addr == AST_OFS_MODE)
            mode_r <= wdata;
         if (addr == AST_OFS_CTRL)
            ctrl_r <= wdata;
         if (addr == AST_OFS_DIV)
            div_r <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         tx_buffer_r <= 8'h00;
      else if (ce && wr && addr == AST_OFS_TXBUF)
         tx_buffer_r <= wdata;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rdata_r <= 8'h00;
      else if (ce)
      begin
         rdata_r <= 8'h00;
         if (rd)
         begin
            unique case (addr)
               AST_OFS_MODE:  rdata_r <= mode_r;
               AST_OFS_CTRL:  rdata_r <= ctrl_r;
               AST_OFS_STAT:  rdata_r <= stat_r;
               AST_OFS_TXBUF: rdata_r <= tx_buffer_r;
               AST_OFS_RXBUF: rdata_r <= rx_buffer_r;
               AST_OFS_DIV:   rdata_r <= div_r;
               default:       rdata_r <= 8'h00;
            endcase
         end
      end
   end
   assign rdata = rdata_r;

   // ****************************************
   // Status flags, set wins over clear
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         stat_r <= AST_STAT_RST;
      end
      else if (ce)
      begin
         if (wr_stat)
         begin
            stat_r.multiproc_tx_bit <= wdata[0];
            if (!wdata[6])
               stat_r.rx_full_flag <= 1'b0;
            if (!wdata[5])
               stat_r.overrun_flag <= 1'b0;
            if (!wdata[4])
               stat_r.framing_flag <= 1'b0;
            if (!wdata[3])
               stat_r.parity_flag <= 1'b0;
            if (!wdata[2])
               stat_r.tx_end_flag <= 1'b0;
         end
         if (rd && addr == AST_OFS_RXBUF)
            stat_r.rx_full_flag <= 1'b0;
         if (wr && addr == AST_OFS_TXBUF && ctrl_r.tx_enable)
         begin
            stat_r.tx_empty_flag <= 1'b0;
            stat_r.tx_end_flag   <= 1'b0;
         end
         if (tx_load || !ctrl_r.tx_enable)
            stat_r.tx_empty_flag <= 1'b1;
         if (tx_finish)
            stat_r.tx_end_flag <= 1'b1;
         if (rx_done)
         begin
            stat_r.multiproc_bit <= rx_par_r;
            if (stat_r.rx_full_flag)
               stat_r.overrun_flag <= 1'b1;
            else
            begin
               if (!rx_line)
                  stat_r.framing_flag <= 1'b1;
               if (par_bad)
                  stat_r.parity_flag <= 1'b1;
               if (rx_line && !par_bad)
                  stat_r.rx_full_flag <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // Interrupt requests
   // ****************************************
   assign tx_empty_irq = stat_r.tx_empty_flag & ctrl_r.tx_empty_irq_en;
   assign tx_end_irq   = stat_r.tx_end_flag & ctrl_r.tx_end_irq_en;
   assign rx_full_irq  = stat_r.rx_full_flag & ctrl_r.rx_irq_en;
   assign rx_error_irq = rx_err_any & ctrl_r.rx_irq_en;

   // ****************************************
   // Transmitter
   // ****************************************
   assign tx_bnd    = tick && (tx_ph_r == AST_PH_LAST);
   assign tx_load   = ce && tx_bnd && ctrl_r.tx_enable && !stat_r.tx_empty_flag &&
                      ((tx_st_r == AST_TX_IDLE) ||
                       (tx_st_r == AST_TX_STOP &&
                        tx_cnt_r == {2'b00, mode_r.two_stop_select}));
   assign tx_finish = ce && tx_bnd && ctrl_r.tx_enable && stat_r.tx_empty_flag &&
                      tx_st_r == AST_TX_STOP &&
                      tx_cnt_r == {2'b00, mode_r.two_stop_select};

   always_ff @(posedge clk)
   begin
      if (srst)
         tx_ph_r <= 4'h0;
      else if (ce && tick)
         tx_ph_r <= tx_ph_r + 4'h1;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_st_r      <= AST_TX_IDLE;
         tx_cnt_r     <= 3'h0;
         tx_shifter_r <= 8'h00;
         tx_par_r     <= 1'b0;
      end
      else if (ce)
      begin
         if (!ctrl_r.tx_enable)
            tx_st_r <= AST_TX_IDLE;
         else if (tx_load)
         begin
            tx_st_r      <= AST_TX_START;
            tx_shifter_r <= tx_buffer_r & {~mode_r.seven_bit_select, 7'h7f};
            tx_par_r     <= mode_r.multiproc_format ? stat_r.multiproc_tx_bit :
                            (^(tx_buffer_r & {~mode_r.seven_bit_select, 7'h7f})) ^
                            mode_r.parity_odd_select;
         end
         else if (tx_bnd)
         begin
            unique case (tx_st_r)
               AST_TX_IDLE:
                  tx_st_r <= AST_TX_IDLE;
               AST_TX_START:
               begin
                  tx_st_r  <= AST_TX_DATA;
                  tx_cnt_r <= 3'h0;
               end
               AST_TX_DATA:
               begin
                  if (tx_cnt_r == last_data)
                  begin
                     tx_st_r  <= has_pbit ? AST_TX_PAR : AST_TX_STOP;
                     tx_cnt_r <= 3'h0;
                  end
                  else
                     tx_cnt_r <= tx_cnt_r + 3'h1;
               end
               AST_TX_PAR:
               begin
                  tx_st_r  <= AST_TX_STOP;
                  tx_cnt_r <= 3'h0;
               end
               AST_TX_STOP:
               begin
                  if (tx_cnt_r == {2'b00, mode_r.two_stop_select})
                     tx_st_r <= AST_TX_IDLE;
                  else
                     tx_cnt_r <= tx_cnt_r + 3'h1;
               end
            endcase
         end
      end
   end

   always_comb
   begin
      unique case (tx_st_r)
         AST_TX_IDLE:  txd_nxt = 1'b1;
         AST_TX_START: txd_nxt = 1'b0;
         AST_TX_DATA:  txd_nxt = tx_shifter_r[tx_cnt_r];
         AST_TX_PAR:   txd_nxt = tx_par_r;
         AST_TX_STOP:  txd_nxt = 1'b1;
         default:      txd_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         txd_r <= 1'b1;
      else if (ce)
         txd_r <= txd_nxt;
   end
   assign txd = txd_r;

   // ****************************************
   // Receiver
   // ****************************************
   assign rx_start = ce && ctrl_r.rx_enable && !rx_err_any && (rx_st_r == AST_RX_IDLE) &&
                     rxd_sync_r[2] && !rx_line;
   assign rx_smp   = ce && tick && (rx_ph_r == AST_PH_SAMPLE) && (rx_st_r != AST_RX_IDLE);
   assign rx_done  = rx_smp && (rx_st_r == AST_RX_STOP) && ctrl_r.rx_enable;
   assign par_bad  = mode_r.parity_enable && !mode_r.multiproc_format &&
                     ((^rx_shifter_r) ^ rx_par_r ^ mode_r.parity_odd_select);

   always_ff @(posedge clk)
   begin
      if (srst)
         rx_ph_r <= 4'h0;
      else if (rx_start)
         rx_ph_r <= 4'h0;
      else if (ce && tick)
         rx_ph_r <= rx_ph_r + 4'h1;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rx_st_r      <= AST_RX_IDLE;
         rx_cnt_r     <= 3'h0;
         rx_shifter_r <= 8'h00;
         rx_par_r     <= 1'b0;
      end
      else if (ce)
      begin
         if (!ctrl_r.rx_enable)
            rx_st_r <= AST_RX_IDLE;
         else if (rx_start)
         begin
            rx_st_r      <= AST_RX_START;
            rx_shifter_r <= 8'h00;
            rx_par_r     <= 1'b0;
         end
         else if (rx_smp)
         begin
            unique case (rx_st_r)
               AST_RX_IDLE:
                  rx_st_r <= AST_RX_IDLE;
               AST_RX_START:
               begin
                  rx_st_r  <= rx_line ? AST_RX_IDLE : AST_RX_DATA;
                  rx_cnt_r <= 3'h0;
               end
               AST_RX_DATA:
               begin
                  rx_shifter_r[rx_cnt_r] <= rx_line;
                  if (rx_cnt_r == last_data)
                     rx_st_r <= has_pbit ? AST_RX_PAR : AST_RX_STOP;
                  else
                     rx_cnt_r <= rx_cnt_r + 3'h1;
               end
               AST_RX_PAR:
                  rx_st_r <= AST_RX_STOP;
               AST_RX_STOP:
                  rx_st_r <= AST_RX_IDLE;
            endcase
            if (rx_st_r == AST_RX_PAR)
               rx_par_r <= rx_line;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rx_buffer_r <= 8'h00;
      else if (rx_done && !stat_r.rx_full_flag)
         rx_buffer_r <= rx_shifter_r;
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_tx_stop_end;
      ce && tx_bnd && tx_st_r == AST_TX_STOP && ctrl_r.tx_enable &&
      tx_cnt_r == {2'b00, mode_r.two_stop_select};
   endsequence

   a_tx_idle_line: assert property (ce && tx_st_r == AST_TX_IDLE |=> txd)
      else $error("line not high while idle");
   a_tx_start_low: assert property ($rose(tx_st_r == AST_TX_START) |=> !txd)
      else $error("start bit not low");
   a_tx_load_flag: assert property (tx_load |=> stat_r.tx_empty_flag &&
                                    tx_st_r == AST_TX_START)
      else $error("buffer load did not set empty flag");
   a_tx_off_empty: assert property (ce && !ctrl_r.tx_enable |=> stat_r.tx_empty_flag)
      else $error("empty flag not set after disable");
   a_tx_end_set: assert property (s_tx_stop_end ##0 stat_r.tx_empty_flag |=>
                                  stat_r.tx_end_flag && tx_st_r == AST_TX_IDLE)
      else $error("end flag not set");
   a_tx_chain: assert property (s_tx_stop_end ##0 !stat_r.tx_empty_flag |=>
                                tx_st_r == AST_TX_START)
      else $error("next frame not chained");
   a_rx_sample_mid: assert property (rx_start |=> rx_ph_r == 4'h0 &&
                                     rx_st_r == AST_RX_START)
      else $error("start edge did not resync the sample phase");
   a_rx_overrun_drop: assert property (rx_done && stat_r.rx_full_flag |=>
                                       stat_r.overrun_flag && $stable(rx_buffer_r))
      else $error("overrun mishandled");
   a_rx_good_store: assert property (rx_done && !stat_r.rx_full_flag && rx_line && !par_bad
                                     |=> stat_r.rx_full_flag &&
                                     rx_buffer_r == $past(rx_shifter_r))
      else $error("good character not stored");
   a_rx_frame_keep: assert property (rx_done && !stat_r.rx_full_flag && !rx_line |=>
                                     stat_r.framing_flag && !stat_r.rx_full_flag)
      else $error("framing error mishandled");
   a_rx_err_block: assert property (rx_err_any && rx_st_r == AST_RX_IDLE |=>
                                    rx_st_r == AST_RX_IDLE)
      else $error("reception started with error set");
   a_sck_centre: assert property (ce && tick && tx_ph_r == 4'h7 |=> serial_clk_out)
      else $error("clock output edge not at centre");

endmodule

`default_nettype wire

// ===== ast_serial_unit_tb.sv
// Testbench for the serial unit: register tasks, frames both ways, errors.
// Assumes the remote model drives rxd and the external 16x clock.
`timescale 1ns/1ps
`default_nettype none

module ast_serial_unit_tb
   import ast_pkg::*;
   ;
   localparam int LIMIT = 20000;
   localparam int BT    = 16;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        ce = 1'b1;
   logic [2:0]  addr = 3'h0;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdata;
   logic        rxd, txd, sclk_in, sclk_out, sclk_oe;
   logic        tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          nb;
   time         ta;
   logic [7:0]  m, d, s, dm;
   logic [11:0] g, c0, c1, mk;
   logic [2:0]  ra [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
   logic [7:0]  re [5] = '{AST_MODE_RST, AST_CTRL_RST, AST_STAT_RST, AST_DIV_RST, 8'h00};

   always #10 clk = ~clk;

   ast_serial_unit ast_serial_unit_inst (
      .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .serial_clk_in(sclk_in),
      .serial_clk_out(sclk_out), .serial_clk_oe(sclk_oe),
      .tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq),
      .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq)
   );

   ast_remote ast_remote_inst (
      .clk(clk), .txd(txd), .sclk(sclk_out), .rxd(rxd), .ext_clk(sclk_in)
   );

   // ****************************
   // Tasks
   // ****************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (n_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic poll(input int b, input logic v);
      logic [7:0] x;
      x = ~{8{v}};
      for (int k = 0; k < 300 && x[b] !== v; k++)
         rd_reg(AST_OFS_STAT, x);
      check(x[b], v);
   endtask

   function automatic logic [11:0] mkf(input logic [7:0] md, input logic [7:0] dt,
                                       input logic mp, input logic sb);
      logic [11:0] r;
      int          n;
      r = '1;
      n = md[6] ? 7 : 8;
      r[0] = 1'b0;
      for (int i = 0; i < n; i++)
         r[i + 1] = dt[i];
      if (md[2])
         r[n + 1] = mp;
      else if (md[5])
         r[n + 1] = ^(dt & (md[6] ? 8'h7f : 8'hff)) ^ md[4];
      r[n + 1 + (md[2] | md[5])] = sb;
      return r;
   endfunction

   // ****************************
   // Sequence
   // ****************************
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         n_errors++;
         stop_test();
      end
   end

   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         rd_reg(ra[i], s);
         check(s, re[i]);
      end
      check(txd, 1'b1);
      wr_reg(AST_OFS_DIV, 8'h00);
      for (int i = 0; i < 12; i++)
      begin
         m = {1'b0, (i < 8) ? i[2] : i[1], (i < 8) & i[1], i[0] ^ i[1], i[0], i >= 8, 2'b00};
         d = 8'(8'h5a + i * 29);
         dm = m[6] ? 8'h7f : 8'hff;
         nb = 2 + (m[6] ? 7 : 8) + (m[5] | m[2]) + m[3];
         mk = ~(12'hfff << nb);
         wr_reg(AST_OFS_CTRL, 8'h00);
         wr_reg(AST_OFS_MODE, m);
         wr_reg(AST_OFS_CTRL, 8'h71);
         check(sclk_oe, 1'b1);
         fork
            ast_remote_inst.recv(nb, BT, g, c0, c1);
            wr_reg(AST_OFS_TXBUF, d);
         join
         check(g & mk, mkf(m, d, 1'b0, 1'b1) & mk);
         check(c0 & mk, 12'h000);
         check(c1 & (mk >> 1), mk >> 1);
         poll(2, 1'b1);
         ast_remote_inst.send(mkf(m, ~d, 1'b1, 1'b1), nb, BT);
         rd_reg(AST_OFS_STAT, s);
         check(s[6:1] & {5'h1f, m[2]}, {5'h11, m[2]});
         check(rx_full_irq, 1'b1);
         rd_reg(AST_OFS_RXBUF, s);
         check(s & dm, ~d & dm);
      end
      wr_reg(AST_OFS_CTRL, 8'h00);
      wr_reg(AST_OFS_MODE, 8'h00);
      wr_reg(AST_OFS_CTRL, 8'ha4);
      fork
         ast_remote_inst.recv(10, BT, g, c0, c1);
         begin
            wr_reg(AST_OFS_TXBUF, 8'hc3);
            poll(7, 1'b1);
            wr_reg(AST_OFS_TXBUF, 8'h3c);
         end
      join
      ta = ast_remote_inst.t0;
      check(g & 12'h3ff, mkf(8'h00, 8'hc3, 1'b0, 1'b1) & 12'h3ff);
      ast_remote_inst.recv(10, BT, g, c0, c1);
      check(16'(ast_remote_inst.t0 - ta), 16'(10 * BT * 20));
      check(g & 12'h3ff, mkf(8'h00, 8'h3c, 1'b0, 1'b1) & 12'h3ff);
      poll(2, 1'b1);
      check({tx_empty_irq, tx_end_irq}, 2'b11);
      wr_reg(AST_OFS_TXBUF, 8'h81);
      poll(7, 1'b1);
      wr_reg(AST_OFS_TXBUF, 8'h18);
      rd_reg(AST_OFS_STAT, s);
      check(s[7], 1'b0);
      wr_reg(AST_OFS_CTRL, 8'h00);
      rd_reg(AST_OFS_STAT, s);
      check({s[7], txd}, 2'b11);
      wr_reg(AST_OFS_CTRL, 8'h02);
      wr_reg(AST_OFS_CTRL, 8'h22);
      check(sclk_oe, 1'b0);
      fork
         ast_remote_inst.recv(10, 64, g, c0, c1);
         wr_reg(AST_OFS_TXBUF, 8'h96);
      join
      check(g & 12'h3ff, mkf(8'h00, 8'h96, 1'b0, 1'b1) & 12'h3ff);
      wr_reg(AST_OFS_CTRL, 8'h00);
      wr_reg(AST_OFS_CTRL, 8'h50);
      ast_remote_inst.send(mkf(8'h00, 8'h11, 1'b0, 1'b1), 10, BT);
      ast_remote_inst.send(mkf(8'h00, 8'h22, 1'b0, 1'b1), 10, BT);
      rd_reg(AST_OFS_STAT, s);
      check({s[6:5], rx_error_irq}, 3'b111);
      ast_remote_inst.send(mkf(8'h00, 8'h33, 1'b0, 1'b1), 10, BT);
      rd_reg(AST_OFS_RXBUF, s);
      check(s, 8'h11);
      wr_reg(AST_OFS_STAT, 8'h00);
      ast_remote_inst.send(mkf(8'h00, 8'h44, 1'b0, 1'b0), 10, BT);
      rd_reg(AST_OFS_STAT, s);
      check(s[6:3], 4'h2);
      wr_reg(AST_OFS_CTRL, 8'h00);
      rd_reg(AST_OFS_STAT, s);
      check(s[6:3], 4'h2);
      rd_reg(AST_OFS_RXBUF, s);
      check(s, 8'h44);
      wr_reg(AST_OFS_STAT, 8'h00);
      wr_reg(AST_OFS_MODE, 8'h28);
      wr_reg(AST_OFS_CTRL, 8'h10);
      ast_remote_inst.send(mkf(8'h28, 8'h55, 1'b0, 1'b1) ^ 12'ha00, 12, BT);
      rd_reg(AST_OFS_STAT, s);
      check(s[6:3], 4'h1);
      rd_reg(AST_OFS_RXBUF, s);
      check(s, 8'h55);
      stop_test();
   end
endmodule

`default_nettype wire
